/* File: fsw_cmd_front.sv */
// Serial flash instruction front end: lanes, framing, write latch, status readout
`timescale 1ns/10ps
`include "fsw_defines.svh"
// Function
// - Opcode, address and data travel MSB first; device drives returned fields only.
// - Status readout repeats until select is released.
// - Programs take 1 to 256 bytes; extra bytes wrap within the page.
// - Security registers: upper byte zero, bits 15-9 pick register, 8-0 byte.
// - Dual address entry: lane one odd bits, lane zero even, two per clock.
// - Dual output: bits 7,5,3,1 on lane one, 6,4,2,0 on lane zero.
// - Quad address entry: lane three takes the top bit of each nibble.
// - Quad output: upper nibble then lower, lane three bits 7 and 3.
// - Quad I/O read: six don't-care clocks, then nibbles upper first.
// - Write enable opcode sets the write latch flag.
// - Program and erase run only with the write latch set; status write with it or after volatile enable.
// - Volatile enable arms a status write only in the next recognised frame, leaves the latch alone.
// - Write disable opcode clears the write latch flag.
// - Latch clears at reset and on completion of every write operation, except when a write enable frame ends in that cycle.
// - Opcodes 05h and 35h pick status register one or two.
// - Selected status byte leaves on falling clock edges, MSB first.
// - Status reads are served at any time, busy included.
// - Write-type frames not ending on a byte boundary are discarded.
// - Busy stays high for a status write until the cycle ends.
module fsw_cmd_front
    import fsw_pkg::*;
(
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Serial link
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        lane_zero_i,
    output logic             lane_zero_o,
    output logic             lane_zero_oe,
    input  wire logic        lane_one_i,
    output logic             lane_one_o,
    output logic             lane_one_oe,
    input  wire logic        lane_two_i,
    output logic             lane_two_o,
    output logic             lane_two_oe,
    input  wire logic        lane_three_i,
    output logic             lane_three_o,
    output logic             lane_three_oe,
    // Operation request to the array
    output logic             op_start,
    output logic [7:0]       op_code,
    output logic [23:0]      op_addr,
    output logic [8:0]       op_len,
    output logic             op_volatile,
    input  wire logic        op_done,
    // Page data buffer read port
    input  wire logic [7:0]  buf_rd_addr,
    output logic      [7:0]  buf_rd_data,
    // Array read data
    output logic      [23:0] array_addr,
    input  wire logic [7:0]  array_data,
    // Status
    input  wire logic [13:0] status_ext,
    output logic             busy_flag,
    output logic             write_latch_flag
);

    // ------------------------------------------------------------------
    // Link side: byte assembly on rising serial clock
    // ------------------------------------------------------------------
    logic        act_r;
    logic        tog_r = 1'b0;
    fsw_phase_t  ph_r;
    fsw_phase_t  ph_nxt;
    logic [7:0]  opc_r;
    logic [7:0]  opc_nxt;
    logic [7:0]  sh_r;
    logic [2:0]  bits_r;
    logic [2:0]  tb_r;
    logic [2:0]  tb_nxt;
    logic [2:0]  cnt_r;
    logic [2:0]  cnt_nxt;
    logic [7:0]  col_r;
    logic [7:0]  col_nxt;
    logic [23:0] addr_r;
    logic [23:0] addr_nxt;
    logic [8:0]  dcnt_r;
    logic [8:0]  dcnt_nxt;
    logic [15:0] st_s1_r;
    logic [15:0] st_s2_r;
    logic [7:0]  arr_s1_r;
    logic [7:0]  arr_s2_r;

    wire fsw_phase_t ph_c = act_r ? ph_r : PH_OPC;
    wire [2:0] bits_c = act_r ? bits_r : 3'h0;
    wire [2:0] tb_c   = act_r ? tb_r : 3'h0;

    wire dio   = (opc_r == `FSW_OP_DIO_RD);
    wire qio   = (opc_r == `FSW_OP_QIO_RD);
    wire in_ax = (ph_c == PH_ADDR) || (ph_c == PH_EXTRA);
    wire w_dual = (in_ax && dio) || (ph_c == PH_DIN && opc_r == `FSW_OP_DPP)
                || (ph_c == PH_DOUT && (dio || opc_r == `FSW_OP_DOUT_RD));
    wire w_quad = (in_ax && qio) || (ph_c == PH_DIN && opc_r == `FSW_OP_QPP)
                || (ph_c == PH_DOUT && (qio || opc_r == `FSW_OP_QOUT_RD));
    wire [2:0] w_c = w_quad ? 3'h4 : (w_dual ? 3'h2 : 3'h1);

    // Lane three, two, one, zero carry successively lower bits
    wire [7:0] sh_in = w_quad ? {sh_r[3:0], lane_three_i, lane_two_i, lane_one_i, lane_zero_i}
                     : w_dual ? {sh_r[5:0], lane_one_i, lane_zero_i}
                     : {sh_r[6:0], lane_zero_i};
    wire [3:0] bsum      = {1'b0, bits_c} + {1'b0, w_c};
    wire       byte_done = bsum[3];

    // Opcode classes
    wire o_addr = (sh_in == `FSW_OP_PP) || (sh_in == `FSW_OP_DPP) || (sh_in == `FSW_OP_QPP)
                || (sh_in == `FSW_OP_PE_A) || (sh_in == `FSW_OP_PE_B) || (sh_in == `FSW_OP_SE)
                || (sh_in == `FSW_OP_BE32) || (sh_in == `FSW_OP_BE64)
                || (sh_in == `FSW_OP_SEC_ER) || (sh_in == `FSW_OP_SEC_PG)
                || (sh_in == `FSW_OP_SEC_RD) || (sh_in == `FSW_OP_READ)
                || (sh_in == `FSW_OP_FREAD) || (sh_in == `FSW_OP_DOUT_RD)
                || (sh_in == `FSW_OP_DIO_RD) || (sh_in == `FSW_OP_QOUT_RD)
                || (sh_in == `FSW_OP_QIO_RD);
    wire o_stat = (sh_in == `FSW_OP_RDSR1) || (sh_in == `FSW_OP_RDSR2);
    wire is_prog = (opc_r == `FSW_OP_PP) || (opc_r == `FSW_OP_DPP)
                 || (opc_r == `FSW_OP_QPP) || (opc_r == `FSW_OP_SEC_PG);
    wire has_ext = (opc_r == `FSW_OP_FREAD) || (opc_r == `FSW_OP_DOUT_RD)
                 || (opc_r == `FSW_OP_QOUT_RD) || (opc_r == `FSW_OP_SEC_RD) || dio || qio;
    wire is_read = has_ext || (opc_r == `FSW_OP_READ);
    wire [2:0] ext_last = qio ? `FSW_QIO_EXTRA : 3'h0;

    always_comb
    begin
        ph_nxt   = ph_c;
        opc_nxt  = opc_r;
        cnt_nxt  = act_r ? cnt_r : 3'h0;
        col_nxt  = col_r;
        addr_nxt = addr_r;
        dcnt_nxt = act_r ? dcnt_r : 9'h000;
        tb_nxt   = tb_c;
        if (byte_done)
        begin
            if (tb_c != 3'h7)
                tb_nxt = tb_c + 3'h1;
            cnt_nxt = cnt_nxt + 3'h1;
            unique case (ph_c)
                PH_OPC:
                begin
                    opc_nxt  = sh_in;
                    cnt_nxt  = 3'h0;
                    col_nxt  = 8'h00;
                    addr_nxt = 24'h000000;
                    if (o_addr)
                        ph_nxt = PH_ADDR;
                    else if (o_stat)
                        ph_nxt = PH_DOUT;
                    else if (sh_in == `FSW_OP_WRSR)
                        ph_nxt = PH_DIN;
                    else
                        ph_nxt = PH_IGN;
                end
                PH_ADDR:
                begin
                    addr_nxt = {addr_r[15:0], sh_in};
                    if (cnt_r == 3'h2)
                    begin
                        cnt_nxt = 3'h0;
                        col_nxt = sh_in;
                        if (is_prog)
                            ph_nxt = PH_DIN;
                        else if (has_ext)
                            ph_nxt = PH_EXTRA;
                        else if (is_read)
                            ph_nxt = PH_DOUT;
                        else
                            ph_nxt = PH_IGN;
                    end
                end
                PH_EXTRA:
                begin
                    if (cnt_r == ext_last)
                        ph_nxt = PH_DOUT;
                end
                PH_DIN:
                begin
                    col_nxt = col_r + 8'h01;
                    if (dcnt_r != `FSW_PAGE_BYTES)
                        dcnt_nxt = dcnt_r + 9'h001;
                end
                PH_DOUT:
                begin
                    addr_nxt = addr_r + 24'h000001;
                end
                PH_IGN:
                begin
                end
                default:
                begin
                    ph_nxt = PH_IGN;
                end
            endcase
        end
    end

    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            act_r <= 1'b0;
        else
            act_r <= 1'b1;
    end

    always_ff @(posedge sclk)
    begin
        if (!act_r)
            tog_r <= ~tog_r;
        ph_r     <= ph_nxt;
        opc_r    <= opc_nxt;
        sh_r     <= sh_in;
        bits_r   <= bsum[2:0];
        tb_r     <= tb_nxt;
        cnt_r    <= cnt_nxt;
        col_r    <= col_nxt;
        addr_r   <= addr_nxt;
        dcnt_r   <= dcnt_nxt;
        st_s1_r  <= {status_ext, write_latch_flag, busy_flag};
        st_s2_r  <= st_s1_r;
        arr_s1_r <= array_data;
        arr_s2_r <= arr_s1_r;
    end

    assign array_addr = addr_r;

    fsw_page_mem u_page_mem
    (
        .wclk  (sclk),
        .we    (ph_c == PH_DIN && byte_done),
        .waddr (col_r),
        .wdata (sh_in),
        .rclk  (clk),
        .raddr (buf_rd_addr),
        .rdata (buf_rd_data)
    );

    // ------------------------------------------------------------------
    // Link side: output lanes on falling serial clock
    // ------------------------------------------------------------------
    logic [7:0] osh_r;
    logic [2:0] ocnt_r;
    logic [3:0] lo_r;
    logic [3:0] loe_r;

    wire       out_on = act_r && (ph_r == PH_DOUT);
    wire [7:0] src = (opc_r == `FSW_OP_RDSR1) ? st_s2_r[7:0]
                   : (opc_r == `FSW_OP_RDSR2) ? st_s2_r[15:8] : arr_s2_r;
    // Reload on every byte boundary so a status byte repeats
    wire [7:0] cur = (ocnt_r == 3'h0) ? src : osh_r;
    wire [3:0] lo_nxt  = w_quad ? cur[7:4]
                       : w_dual ? {2'b00, cur[7], cur[6]}
                       : {2'b00, cur[7], 1'b0};
    wire [3:0] loe_nxt = w_quad ? 4'hF : (w_dual ? 4'h3 : 4'h2);
    wire [7:0] osh_nxt = w_quad ? {cur[3:0], 4'h0}
                       : w_dual ? {cur[5:0], 2'b00} : {cur[6:0], 1'b0};

    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            osh_r  <= 8'h00;
            ocnt_r <= 3'h0;
            lo_r   <= 4'h0;
            loe_r  <= 4'h0;
        end
        else if (out_on)
        begin
            osh_r  <= osh_nxt;
            ocnt_r <= ocnt_r + w_c;
            lo_r   <= lo_nxt;
            loe_r  <= loe_nxt;
        end
        else
        begin
            loe_r <= 4'h0;
        end
    end

    assign lane_zero_o   = lo_r[0];
    assign lane_one_o    = lo_r[1];
    assign lane_two_o    = lo_r[2];
    assign lane_three_o  = lo_r[3];
    assign lane_zero_oe  = loe_r[0];
    assign lane_one_oe   = loe_r[1];
    assign lane_two_oe   = loe_r[2];
    assign lane_three_oe = loe_r[3];

    // ------------------------------------------------------------------
    // System side: frame end detection and command execution
    // ------------------------------------------------------------------
    logic [2:0] cs_sync_r;
    logic       cs_q_r;
    logic       tog_seen_r;
    logic       wel_r;
    logic       busy_r;
    logic       vol_r;
    logic       start_r;

    wire agree  = (cs_sync_r[1] == cs_sync_r[2]);
    // Link registers are frozen once select is high, so they are read here
    wire fe     = agree && cs_sync_r[2] && !cs_q_r && (tog_r != tog_seen_r);
    wire whole  = (bits_r == 3'h0);
    wire hdr_ok = fe && whole;
    wire sec_ok = (addr_r[23:16] == `FSW_SEC_HI)
                && ((addr_r[15:9] == `FSW_SEC_REG1) || (addr_r[15:9] == `FSW_SEC_REG2)
                || (addr_r[15:9] == `FSW_SEC_REG3));
    wire is_erase = (opc_r == `FSW_OP_PE_A) || (opc_r == `FSW_OP_PE_B)
                  || (opc_r == `FSW_OP_SE) || (opc_r == `FSW_OP_BE32)
                  || (opc_r == `FSW_OP_BE64) || (opc_r == `FSW_OP_SEC_ER);
    wire sec_gate = !((opc_r == `FSW_OP_SEC_ER) || (opc_r == `FSW_OP_SEC_PG)) || sec_ok;
    wire wren = hdr_ok && (opc_r == `FSW_OP_WREN);
    wire wrdi = hdr_ok && (opc_r == `FSW_OP_WRDI);
    wire vwen = hdr_ok && (opc_r == `FSW_OP_VWREN);
    wire pe_go = hdr_ok && wel_r && !busy_r && sec_gate
               && ((is_prog && dcnt_r != 9'h000)
               || (is_erase && tb_r == `FSW_ERASE_BYTES));
    wire sr_go = hdr_ok && (wel_r || vol_r) && !busy_r && (opc_r == `FSW_OP_WRSR)
               && (tb_r == 3'h2 || tb_r == 3'h3);
    wire known = is_prog || is_erase || is_read || (opc_r == `FSW_OP_WRSR)
               || (opc_r == `FSW_OP_WREN) || (opc_r == `FSW_OP_VWREN)
               || (opc_r == `FSW_OP_WRDI) || (opc_r == `FSW_OP_RDSR1) || (opc_r == `FSW_OP_RDSR2);

    always_ff @(posedge clk)
    begin
        cs_sync_r <= {cs_sync_r[1:0], cs_n};
        if (rst)
        begin
            cs_q_r     <= 1'b1;
            tog_seen_r <= tog_r;
        end
        else
        begin
            if (agree)
                cs_q_r <= cs_sync_r[2];
            if (agree && cs_sync_r[2] && !cs_q_r)
                tog_seen_r <= tog_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wel_r <= `FSW_WEL_RST;
            busy_r <= `FSW_BUSY_RST;
            vol_r <= 1'b0;
        end
        else
        begin
            if (op_done || wrdi)
                wel_r <= 1'b0;
            if (wren)
                wel_r <= 1'b1;
            if (op_done)
                busy_r <= 1'b0;
            if (pe_go || sr_go)
                busy_r <= 1'b1;
            if (fe && known)
                vol_r <= vwen;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            start_r     <= 1'b0;
            op_code     <= 8'h00;
            op_addr     <= 24'h000000;
            op_len      <= 9'h000;
            op_volatile <= 1'b0;
        end
        else
        begin
            start_r <= pe_go || sr_go;
            if (pe_go || sr_go)
            begin
                op_code     <= opc_r;
                op_addr     <= addr_r;
                op_len      <= dcnt_r;
                op_volatile <= sr_go && vol_r;
            end
        end
    end

    assign op_start         = start_r;
    assign busy_flag        = busy_r;
    assign write_latch_flag = wel_r;

endmodule

/* File: fsw_defines.svh */
// Constants of the flash front end
`ifndef FSW_DEFINES_SVH
`define FSW_DEFINES_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define FSW_OP_WREN      8'h06
`define FSW_OP_VWREN     8'h50
`define FSW_OP_WRDI      8'h04
`define FSW_OP_RDSR1     8'h05
`define FSW_OP_RDSR2     8'h35
`define FSW_OP_WRSR      8'h01
`define FSW_OP_PP        8'h02
`define FSW_OP_DPP       8'hA2
`define FSW_OP_QPP       8'h32
`define FSW_OP_PE_A      8'h81
`define FSW_OP_PE_B      8'hDB
`define FSW_OP_SE        8'h20
`define FSW_OP_BE32      8'h52
`define FSW_OP_BE64      8'hD8
`define FSW_OP_SEC_ER    8'h44
`define FSW_OP_SEC_PG    8'h42
`define FSW_OP_SEC_RD    8'h48
`define FSW_OP_READ      8'h03
`define FSW_OP_FREAD     8'h0B
`define FSW_OP_DOUT_RD   8'h3B
`define FSW_OP_DIO_RD    8'hBB
`define FSW_OP_QOUT_RD   8'h6B
`define FSW_OP_QIO_RD    8'hEB

// ----------------------------------------------------------------------
// Status bits, frame counts and security register address
// ----------------------------------------------------------------------
`define FSW_SR_BUSY_BIT  0
`define FSW_SR_WEL_BIT   1
`define FSW_WEL_RST      1'b0
`define FSW_BUSY_RST     1'b0
`define FSW_PAGE_BYTES   9'h100
`define FSW_ERASE_BYTES  3'h4
`define FSW_QIO_EXTRA    3'h2
`define FSW_SEC_HI       8'h00
`define FSW_SEC_REG1     7'h08
`define FSW_SEC_REG2     7'h10
`define FSW_SEC_REG3     7'h18

`endif

/* File: fsw_pkg.sv */
// Types shared by the flash front end
package fsw_pkg;

    typedef enum logic [2:0]
    {
        PH_OPC   = 3'b000,
        PH_ADDR  = 3'b001,
        PH_EXTRA = 3'b010,
        PH_DIN   = 3'b011,
        PH_DOUT  = 3'b100,
        PH_IGN   = 3'b101
    } fsw_phase_t;

endpackage

/* File: fsw_page_mem.sv */
// Page data buffer: written on the serial clock, read on the system clock
`timescale 1ns/10ps
module fsw_page_mem
(
    // Write side
    input  wire logic       wclk,
    input  wire logic       we,
    input  wire logic [7:0] waddr,
    input  wire logic [7:0] wdata,
    // Read side
    input  wire logic       rclk,
    input  wire logic [7:0] raddr,
    output logic      [7:0] rdata
);

    logic [7:0] mem [0:255];

    always_ff @(posedge wclk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    always_ff @(posedge rclk)
    begin
        rdata <= mem[raddr];
    end

endmodule

/* File: fsw_cmd_front_props.sv */
// Checks on the flash front end ports
`timescale 1ns/10ps
module fsw_cmd_front_props
(
    // Clocks and reset
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        sclk,
    // Link
    input wire logic        cs_n,
    input wire logic        lane_one_o,
    input wire logic        lane_zero_oe,
    input wire logic        lane_one_oe,
    input wire logic        lane_two_oe,
    input wire logic        lane_three_oe,
    // Operation and status
    input wire logic        op_start,
    input wire logic [7:0]  op_code,
    input wire logic [23:0] op_addr,
    input wire logic        op_volatile,
    input wire logic        op_done,
    input wire logic        busy_flag,
    input wire logic        write_latch_flag
);
    // --------
    // Cycles with select high, saturating
    // --------
    logic [3:0] hi_cnt_r;
    logic [3:0] hi_cnt_nxt;
    logic       any_oe;
    logic       frame_end;
    assign any_oe     = lane_zero_oe | lane_one_oe | lane_two_oe | lane_three_oe;
    assign hi_cnt_nxt = (rst || !cs_n) ? 4'h0 : (hi_cnt_r == 4'hF) ? hi_cnt_r : hi_cnt_r + 4'h1;
    assign frame_end  = cs_n && (hi_cnt_r >= 4'h2) && (hi_cnt_r <= 4'h8);
    always_ff @(posedge clk)
    begin
        hi_cnt_r <= hi_cnt_nxt;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_start_needs_latch: assert property (op_start |-> write_latch_flag || op_volatile)
        else $error("no latch at start");
    a_start_sets_busy: assert property (op_start |-> ##[0:1] busy_flag)
        else $error("busy not set");
    a_busy_holds: assert property (busy_flag && !op_done |=> busy_flag)
        else $error("busy dropped");
    a_done_clears_busy: assert property (op_done |=> !busy_flag)
        else $error("busy not cleared");
    a_done_clears_latch: assert property (op_done && hi_cnt_r == 4'hF |=> !write_latch_flag)
        else $error("latch not cleared");
    a_latch_rise_frame: assert property ($rose(write_latch_flag) |-> frame_end)
        else $error("stray latch set");
    a_latch_fall_cause: assert property ($fell(write_latch_flag) |-> $past(op_done) || frame_end)
        else $error("stray latch clear");
    a_idle_no_drive: assert property (cs_n && $past(cs_n) |-> !any_oe)
        else $error("lane driven idle");
    a_out_falling_edge: assert property (lane_one_oe && $past(lane_one_oe) && $changed(lane_one_o)
        |-> !sclk)
        else $error("lane changed on rise");
    a_fields_hold: assert property (!op_start |-> $stable(op_code) && $stable(op_addr))
        else $error("op fields changed");
endmodule
bind fsw_cmd_front fsw_cmd_front_props fsw_cmd_front_props_i
(
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .lane_one_o(lane_one_o),
    .lane_zero_oe(lane_zero_oe), .lane_one_oe(lane_one_oe), .lane_two_oe(lane_two_oe),
    .lane_three_oe(lane_three_oe), .op_start(op_start), .op_code(op_code), .op_addr(op_addr),
    .op_volatile(op_volatile), .op_done(op_done), .busy_flag(busy_flag),
    .write_latch_flag(write_latch_flag)
);

/* File: fsw_host.sv */
// Host controller model driving select, serial clock and lanes
`timescale 1ns/10ps
module fsw_host
(
    // Link outputs
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      h_d,
    // Resolved lane levels
    input  wire logic [3:0] lanes
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b0;
        h_d  = 4'h5;
        // Rising select clears the link logic
        #1 cs_n = 1'b1;
    end
    task automatic sel();
        #37 cs_n = 1'b0;
        #50;
    endtask
    task automatic desel();
        #40 cs_n = 1'b1;
        h_d = ~h_d;
    endtask
    // Shift nb bits of b, w lanes per rising edge, MSB first
    task automatic send(input logic [7:0] b, input int w, input int nb);
        for (int i = 0; i < nb; i += w)
        begin
            h_d = (w == 1) ? {3'h0, b[7-i]} : (w == 2) ? {2'h0, b[7-i-:2]} : b[7-i-:4];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
    endtask
    // Released lanes toggle
    task automatic recv(output logic [7:0] b, input int w);
        b = 8'h00;
        for (int i = 0; i < 8; i += w)
        begin
            h_d = ~h_d;
            #80 sclk = 1'b1;
            b = (w == 1) ? {b[6:0], lanes[1]} : (w == 2) ? {b[5:0], lanes[1:0]} : {b[3:0], lanes};
            #80 sclk = 1'b0;
        end
    endtask
endmodule

/* File: test_fsw_cmd_front.sv */
// Bench of the flash front end
`timescale 1ns/10ps
`include "fsw_defines.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module test_fsw_cmd_front;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sclk, cs_n, op_start, op_volatile, busy_flag, write_latch_flag;
    logic        op_done = 1'b0;
    logic [3:0]  h_d, lanes, d_o, d_oe;
    logic [7:0]  op_code, buf_rd_data;
    logic [7:0]  buf_rd_addr = 8'h00;
    logic [7:0]  array_data = 8'hC6;
    logic [23:0] op_addr;
    logic [8:0]  op_len;
    logic [13:0] status_ext = 14'h2A5C;
    int          n_mismatch = 0;
    int          tests_run = 0;
    assign lanes = (d_oe & d_o) | (~d_oe & h_d);
    always #5 clk = ~clk;
    fsw_cmd_front fsw_cmd_front_i
    (
        .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .lane_zero_i(lanes[0]), .lane_zero_o(d_o[0]), .lane_zero_oe(d_oe[0]),
        .lane_one_i(lanes[1]), .lane_one_o(d_o[1]), .lane_one_oe(d_oe[1]),
        .lane_two_i(lanes[2]), .lane_two_o(d_o[2]), .lane_two_oe(d_oe[2]),
        .lane_three_i(lanes[3]), .lane_three_o(d_o[3]), .lane_three_oe(d_oe[3]),
        .op_start(op_start), .op_code(op_code), .op_addr(op_addr), .op_len(op_len),
        .op_volatile(op_volatile), .op_done(op_done), .buf_rd_addr(buf_rd_addr),
        .buf_rd_data(buf_rd_data), .array_addr(), .array_data(array_data),
        .status_ext(status_ext), .busy_flag(busy_flag), .write_latch_flag(write_latch_flag)
    );
    fsw_host fsw_host_i (.sclk(sclk), .cs_n(cs_n), .h_d(h_d), .lanes(lanes));
    // --------
    // Shared tasks
    // --------
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic clks(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [7:0] dat(input int i);
        return 8'(i) ^ 8'hA5;
    endfunction
    task automatic addr(input logic [23:0] a);
        fsw_host_i.send(a[23:16], 1, 8);
        fsw_host_i.send(a[15:8], 1, 8);
        fsw_host_i.send(a[7:0], 1, 8);
    endtask
    task automatic op1(input logic [7:0] op);
        fsw_host_i.sel();
        fsw_host_i.send(op, 1, 8);
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na);
        op1(op);
        if (na > 0)
            addr(a);
        fsw_host_i.desel();
    endtask
    task automatic cmd(input logic [7:0] op);
        frame(op, 24'h0, 0);
        clks(12);
    endtask
    task automatic prog(input logic [7:0] op, input int w, input logic [23:0] a, input int n);
        op1(op);
        addr(a);
        for (int i = 0; i < n; i++)
            fsw_host_i.send(dat(i), w, 8);
        fsw_host_i.desel();
    endtask
    task automatic wait_op(input logic exp);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 30 && !seen; i++)
        begin
            @(posedge clk);
            #1 seen = op_start;
        end
        `CHK("op_start", exp, seen)
        if (exp && !seen)
            stop_test();
    endtask
    task automatic finish_op();
        clks(5);
        op_done <= 1'b1;
        @(posedge clk);
        op_done <= 1'b0;
        clks(3);
        `CHK("busy_flag", 1'b0, busy_flag)
        `CHK("write_latch_flag", 1'b0, write_latch_flag)
    endtask
    task automatic rdsr(input logic [7:0] op, input logic [7:0] exp);
        logic [7:0] b;
        op1(op);
        repeat (2)
        begin
            fsw_host_i.recv(b, 1);
            `CHK("status byte", exp, b)
        end
        fsw_host_i.desel();
        clks(12);
    endtask
    task automatic chk_buf(input logic [7:0] col, input logic [7:0] exp);
        buf_rd_addr <= col;
        clks(3);
        `CHK("page buffer", exp, buf_rd_data)
    endtask
    // --------
    // Scenarios
    // --------
    task automatic t_reset();
        `CHK("write_latch_flag", 1'b0, write_latch_flag)
        rdsr(`FSW_OP_RDSR1, {status_ext[5:0], 2'b00});
        rdsr(`FSW_OP_RDSR2, status_ext[13:6]);
    endtask
    task automatic t_latch();
        cmd(`FSW_OP_WREN);
        `CHK("wel after enable", 1'b1, write_latch_flag)
        rdsr(`FSW_OP_RDSR1, {status_ext[5:0], 2'b10});
        cmd(8'hFF);
        `CHK("wel after unknown", 1'b1, write_latch_flag)
        op1(`FSW_OP_WRDI);
        fsw_host_i.send(8'h00, 1, 4);
        fsw_host_i.desel();
        clks(12);
        `CHK("wel after partial", 1'b1, write_latch_flag)
        cmd(`FSW_OP_VWREN);
        `CHK("wel after volatile", 1'b1, write_latch_flag)
        cmd(`FSW_OP_WRDI);
        `CHK("wel after disable", 1'b0, write_latch_flag)
        prog(`FSW_OP_PP, 1, 24'h000100, 1);
        wait_op(1'b0);
    endtask
    task automatic t_vol_wrsr();
        cmd(`FSW_OP_VWREN);
        `CHK("wel after volatile", 1'b0, write_latch_flag)
        op1(`FSW_OP_WRSR);
        fsw_host_i.send(8'h3C, 1, 8);
        fsw_host_i.send(8'h01, 1, 8);
        fsw_host_i.desel();
        wait_op(1'b1);
        `CHK("op_volatile", 1'b1, op_volatile)
        finish_op();
    endtask
    task automatic t_page_wrap();
        cmd(`FSW_OP_WREN);
        prog(`FSW_OP_PP, 1, 24'h012310, 258);
        wait_op(1'b1);
        `CHK("op_addr", 24'h012310, op_addr)
        `CHK("op_len", 9'h100, op_len)
        rdsr(`FSW_OP_RDSR1, {status_ext[5:0], 2'b11});
        chk_buf(8'h10, dat(256));
        chk_buf(8'h11, dat(257));
        chk_buf(8'h0F, dat(255));
        finish_op();
        for (int k = 0; k < 2; k++)
        begin
            cmd(`FSW_OP_WREN);
            prog(k ? `FSW_OP_QPP : `FSW_OP_DPP, 2 << k, 24'h000040, 3);
            wait_op(1'b1);
            `CHK("op_code", k ? `FSW_OP_QPP : `FSW_OP_DPP, op_code)
            chk_buf(8'h41, dat(1));
            finish_op();
        end
    endtask
    task automatic t_erase();
        logic [7:0]  ops [8] = '{8'h81, 8'hDB, 8'h20, 8'h52, 8'hD8, 8'h44, 8'h44, 8'h44};
        logic [23:0] adr [8] = '{24'h0A5000, 24'h0A5100, 24'h0A6000, 24'h0A8000, 24'h0B0000,
                                 24'h0011FF, 24'h002000, 24'h003123};
        for (int k = 0; k < 8; k++)
        begin
            cmd(`FSW_OP_WREN);
            frame(ops[k], adr[k], 3);
            wait_op(1'b1);
            `CHK("op_addr", adr[k], op_addr)
            finish_op();
        end
        cmd(`FSW_OP_WREN);
        frame(`FSW_OP_SEC_ER, 24'h004000, 3);
        wait_op(1'b0);
    endtask
    task automatic t_reads();
        logic [7:0] ops [4] = '{8'h3B, 8'h6B, 8'hBB, 8'hEB};
        logic [7:0] b;
        for (int k = 0; k < 4; k++)
        begin
            op1(ops[k]);
            if (k < 2)
                addr(24'h000200);
            for (int j = 0; j < ((k < 2) ? 1 : (k == 2) ? 4 : 6); j++)
                fsw_host_i.send(8'h00, (k < 2) ? 1 : 2 * k - 2, 8);
            repeat (2)
            begin
                fsw_host_i.recv(b, k[0] ? 4 : 2);
                `CHK("read data", array_data, b)
            end
            fsw_host_i.desel();
            clks(12);
        end
    endtask
    initial
    begin
        clks(16);
        rst <= 1'b0;
        clks(2);
        t_reset();
        t_latch();
        t_vol_wrsr();
        t_page_wrap();
        t_erase();
        t_reads();
        stop_test();
    end
    initial
    begin
        #900000;
        n_mismatch++;
        stop_test();
    end
endmodule
